/* File: hw/mi_map.svh */
// Offsets, field positions, reset values and timing of the input decoder.
`ifndef MI_MAP_SVH
`define MI_MAP_SVH

`define CLK_PERIOD_NS       25
`define MS_NS               1000000
`define CYCINT_MIN_MS       50
`define START_MIN_MS        50
`define EXTAUTO_LOW_MIN_MS  50
`define CLRCTL_PULSE_MS     100
`define MF_SETUP_MS         50
`define PANEL_CFG_EXT_SW    3'h5

`define OFS_CTRL            5'h00
`define OFS_CMD             5'h04
`define OFS_MF              5'h08
`define OFS_STATUS          5'h0c
`define OFS_FLAGS           5'h10
`define OFS_OVERRIDE        5'h14

`define CTRL_RST            16'h0000
`define CTRL_CFG_LSB        0
`define CTRL_PANEL_FIT      3
`define CTRL_EXPECT_LSB     4
`define CTRL_SPINDLE        8
`define CTRL_SPEED_WAIT     9
`define CTRL_STORE          10
`define CTRL_JOG            11
`define CTRL_PANEL_START    12
`define CTRL_SINGLE_SEL     13

`define CMD_BLOCK           1
`define CMD_CLEAR           2

`define FLG_DIAG            0
`define FLG_INTERV          1
`define FLG_MF_REFUSED      2
`define FLG_LOOPERR_LSB     4
`define FLAGS_RST           8'h00

`endif

/* File: hw/mi_pkg.sv */
// Types shared by the machine-interface input decoder.
package mi_pkg;

   typedef struct packed {
      logic       cycIntN;
      logic       start;
      logic       estopN;
      logic       nextBlockOk;
      logic       mfReady;
      logic       spindleOk;
      logic       diagnosticRequest;
      logic       extAuto;
      logic       overrideCodeBit4;
      logic       overrideCodeBit3;
      logic       overrideCodeBit2;
      logic       overrideCodeBit1;
      logic [3:0] motionOk;
      logic [3:0] openLoopN;
      logic       speedReached;
   } machine_in_t;

   typedef struct packed {
      logic        haltMotion;
      logic        servoZero;
      logic        spindleStop;
      logic        spindleEnable;
      logic        startOut;
      logic        startOp;
      logic        blockAdvance;
      logic        programSuspend;
      logic        clearCtl;
      logic        forceAuto;
      logic        singleMode;
      logic        storeEnable;
      logic        jogEnable;
      logic        diagActive;
      logic [3:0]  motionExpected;
      logic [3:0]  axisMoveEnable;
      logic [3:0]  loopOpen;
      logic        mfValid;
      logic        mfChange;
      logic [2:0]  mfCode;
      logic [7:0]  mfData;
      logic        overrideValid;
      logic        overrideIsIncr;
      logic [7:0]  overridePct;
      logic [10:0] overrideIncr;
   } machine_out_t;

   typedef enum logic [1:0] {
      MF_IDLE,
      MF_SETUP,
      MF_STROBE,
      MF_RELEASE
   } mf_state_t;

endpackage

/* File: hw/input_sync.sv */
// Two-stage synchroniser for a vector of machine inputs.
`timescale 1ns/1ps
module input_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire logic         clkEn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage1;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         stage1 <= '0;
         dout   <= '0;
      end else if (clkEn) begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule

/* File: hw/min_width.sv */
// Qualifies a level that must stand for a least number of millisecond ticks.
`timescale 1ns/1ps
module min_width #(
   parameter int TICKS = 50
) (
   input  wire logic sys_clk,
   input  wire logic rstn,
   input  wire logic clkEn,
   input  wire logic tick,
   input  wire logic level,
   output logic      qualified
);
   // One extra tick is counted because the first tick may come at once.
   localparam int CW = $clog2(TICKS + 2);
   localparam logic [CW-1:0] LIMIT = CW'(TICKS + 1);

   logic [CW-1:0] count;
   logic [CW-1:0] next_count;

   if (TICKS < 1) begin : g_bad
      $error("min_width: TICKS must be at least one");
   end

   always_comb begin
      next_count = count;
      if (!level) begin
         next_count = '0;
      end else if (tick && count != LIMIT) begin
         next_count = count + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         count <= '0;
      end else if (clkEn) begin
         count <= next_count;
      end
   end

   assign qualified = level && (count == LIMIT);
endmodule

/* File: hw/machine_interface_input_decoder.sv */
// Machine-interface input decoder: qualifies discrete inputs and acts on them.
`timescale 1ns/1ps
`include "mi_map.svh"
module machine_interface_input_decoder
   import mi_pkg::*;
#(
   parameter int       TICK_CYCLES    = (`MS_NS + `CLK_PERIOD_NS - 1)
                                        / `CLK_PERIOD_NS,
   parameter bit       ANALOG_SPINDLE = 1'b1
) (
   input  wire logic          sys_clk,
   input  wire logic          rstn,
   input  wire logic          clkEn,
   input  wire logic [4:0]    address,
   input  wire logic          read,
   input  wire logic          write,
   input  wire logic [31:0]   writedata,
   input  wire logic [3:0]    byteenable,
   output logic      [31:0]   readdata,
   output logic               waitrequest,
   input  wire machine_in_t   machIn,
   output machine_out_t       machOut
);
   localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
   localparam int          CLR_TICKS = `CLRCTL_PULSE_MS;
   localparam logic [6:0]  CLR_LOAD  = 7'(CLR_TICKS);
   localparam logic [6:0]  MF_LOAD   = 7'(`MF_SETUP_MS);

   if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_bad_tick
      $error("TICK_CYCLES must lie between 1 and 65536");
   end

   machine_in_t  pin;
   logic [15:0]  tickCnt;
   logic         tick;
   logic         cycIntQ;
   logic         startQ;
   logic         extLowQ;

   // Bus and control state.
   logic [15:0]  ctrl;
   logic [7:0]   flags;
   logic         halt;
   logic         running;
   logic         pendBlock;
   logic [6:0]   clrCnt;
   logic         extAutoState;
   logic         startQd;
   logic         extLowQd;
   logic         panelD;
   logic [3:0]   loopOpen;
   mf_state_t    mfState;
   logic [6:0]   mfCnt;
   logic [2:0]   mfCode;
   logic [7:0]   mfData;
   logic [15:0]  next_ctrl;
   logic [7:0]   next_flags;
   logic         next_halt;
   logic         next_running;
   logic         next_pendBlock;
   logic [6:0]   next_clrCnt;
   logic         next_extAutoState;
   logic [3:0]   next_loopOpen;
   mf_state_t    next_mfState;
   logic [6:0]   next_mfCnt;
   logic [2:0]   next_mfCode;
   logic [7:0]   next_mfData;
   logic [31:0]  next_readdata;
   logic         next_waitrequest;
   logic         startAccept;
   logic         blockGo;
   machine_out_t next_machOut;

   logic [31:0]  mask;
   logic [31:0]  rdMux;
   logic [15:0]  status;
   logic         wrTake;
   logic         estop;
   logic         clrBusy;
   logic         extRise;
   logic         extLowEv;
   logic         panelRise;
   logic         startEv;
   logic         clrEvent;
   logic [3:0]   loopReq;

   input_sync #(
      .W ($bits(machine_in_t))
   ) u_sync (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .clkEn   (clkEn),
      .din     (machIn),
      .dout    (pin)
   );

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tickCnt <= 16'h0000;
      end else if (clkEn) begin
         tickCnt <= (tickCnt == TICK_LAST) ? 16'h0000 : tickCnt + 16'h0001;
      end
   end
   assign tick = (tickCnt == TICK_LAST);

   min_width #(.TICKS(`CYCINT_MIN_MS)) u_cycint (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .clkEn     (clkEn),
      .tick      (tick),
      .level     (!pin.cycIntN),
      .qualified (cycIntQ)
   );
   min_width #(.TICKS(`START_MIN_MS)) u_start (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .clkEn     (clkEn),
      .tick      (tick),
      .level     (pin.start),
      .qualified (startQ)
   );
   min_width #(.TICKS(`EXTAUTO_LOW_MIN_MS)) u_extlow (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .clkEn     (clkEn),
      .tick      (tick),
      .level     (!pin.extAuto),
      .qualified (extLowQ)
   );

   assign mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                  {8{byteenable[1]}}, {8{byteenable[0]}}};
   // A transfer completes at the edge where waitrequest is sampled low.
   assign wrTake  = write && !waitrequest;
   assign estop   = !pin.estopN;
   assign clrBusy = (clrCnt != 7'h00);
   // Rising edge counts only after a qualified low
   assign extRise   = extLowQd && !extLowQ;
   assign extLowEv  = extLowQ && !extLowQd;
   assign panelRise = ctrl[`CTRL_PANEL_START] && !panelD;
   // Panel start acts directly only in external auto
   assign startEv   = (startQ && !startQd) || (panelRise && extAutoState);
   assign loopReq   = ~pin.openLoopN;

   assign status = {machOut.motionExpected, loopOpen, cycIntQ, clrBusy,
                    extAutoState, (mfState != MF_IDLE),
                    pendBlock && !pin.nextBlockOk, running, estop, halt};

   always_comb begin
      if (address == `OFS_CTRL) begin
         rdMux = {16'h0000, ctrl};
      end else if (address == `OFS_MF) begin
         rdMux = {21'h000000, mfCode, mfData};
      end else if (address == `OFS_STATUS) begin
         rdMux = {16'h0000, status};
      end else if (address == `OFS_FLAGS) begin
         rdMux = {24'h000000, flags};
      end else if (address == `OFS_OVERRIDE) begin
         rdMux = {11'h000, machOut.overrideValid, machOut.overrideIsIncr,
                  machOut.overrideIncr, machOut.overridePct};
      end else begin
         rdMux = 32'h00000000;
      end
   end

   always_comb begin
      next_waitrequest  = !((read || write) && waitrequest);
      next_readdata     = (read && waitrequest) ? rdMux : readdata;
      next_ctrl         = ctrl;
      next_flags        = flags;
      next_halt         = halt;
      next_running      = running;
      next_pendBlock    = pendBlock;
      next_clrCnt       = clrCnt;
      next_extAutoState = extAutoState;
      next_loopOpen     = loopOpen;
      next_mfState      = mfState;
      next_mfCnt        = mfCnt;
      next_mfCode       = mfCode;
      next_mfData       = mfData;
      clrEvent          = 1'b0;
      startAccept       = 1'b0;
      blockGo           = 1'b0;

      if (wrTake && address == `OFS_CTRL) begin
         next_ctrl = (ctrl & ~mask[15:0]) | (writedata[15:0] & mask[15:0]);
      end
      if (wrTake && address == `OFS_CMD && byteenable[0]) begin
         next_pendBlock = pendBlock || writedata[`CMD_BLOCK];
         clrEvent       = writedata[`CMD_CLEAR];
      end
      if (wrTake && address == `OFS_FLAGS) begin
         next_flags = flags & ~(writedata[7:0] & mask[7:0]);
      end

      if (extRise) begin
         next_extAutoState = 1'b1;
         clrEvent          = 1'b1;
      end
      if (extLowEv) begin
         next_extAutoState = 1'b0;
         if (running) begin
            next_flags[`FLG_INTERV] = 1'b1;
            next_running            = 1'b0;
         end
      end

      if (cycIntQ) begin
         next_halt = 1'b1;
      end
      if (startEv && !cycIntQ && !estop && !clrBusy) begin
         startAccept  = 1'b1;
         next_halt    = 1'b0;
         next_running = 1'b1;
      end

      if (running && pendBlock && pin.nextBlockOk && !halt && !clrBusy) begin
         blockGo        = 1'b1;
         next_pendBlock = 1'b0;
      end

      if (pin.diagnosticRequest) begin
         next_flags[`FLG_DIAG] = 1'b1;
      end

      for (int i = 0; i < 4; i++) begin
         if (!loopReq[i]) begin
            next_loopOpen[i] = 1'b0;
         end else if (machOut.motionExpected[i]) begin
            next_flags[`FLG_LOOPERR_LSB + i] = 1'b1;
         end else begin
            next_loopOpen[i] = 1'b1;
         end
      end

      // The sequencer runs on during a refused write so no tick is lost.
      case (mfState)
         MF_SETUP: begin
            if (tick && mfCnt != 7'h00) begin
               next_mfCnt = mfCnt - 7'h01;
            end
            if (mfCnt == 7'h00) begin
               next_mfState = MF_STROBE;
            end
         end
         MF_STROBE: begin
            if (pin.mfReady) begin
               next_mfState = MF_RELEASE;
            end
         end
         MF_RELEASE: begin
            if (!pin.mfReady) begin
               next_mfState = MF_IDLE;
            end
         end
         default: begin
            next_mfState = MF_IDLE;
         end
      endcase
      if (wrTake && address == `OFS_MF) begin
         if (mfState == MF_IDLE && !clrBusy && byteenable[1:0] == 2'b11) begin
            next_mfData  = writedata[7:0];
            next_mfCode  = writedata[10:8];
            next_mfCnt   = MF_LOAD;
            next_mfState = MF_SETUP;
         end else begin
            next_flags[`FLG_MF_REFUSED] = 1'b1;
         end
      end

      if (clrEvent) begin
         next_clrCnt = CLR_LOAD;
      end else if (clrBusy && tick) begin
         next_clrCnt = clrCnt - 7'h01;
      end
      if (clrEvent || clrBusy) begin
         next_halt      = 1'b0;
         next_running   = 1'b0;
         next_pendBlock = 1'b0;
         next_loopOpen  = 4'h0;
         next_mfState   = MF_IDLE;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         waitrequest  <= 1'b1;
         readdata     <= 32'h00000000;
         ctrl         <= `CTRL_RST;
         flags        <= `FLAGS_RST;
         halt         <= 1'b0;
         running      <= 1'b0;
         pendBlock    <= 1'b0;
         clrCnt       <= CLR_LOAD;
         extAutoState <= 1'b0;
         startQd      <= 1'b0;
         extLowQd     <= 1'b0;
         panelD       <= 1'b0;
         loopOpen     <= 4'h0;
         mfState      <= MF_IDLE;
         mfCnt        <= 7'h00;
         mfCode       <= 3'h0;
         mfData       <= 8'h00;
      end else if (clkEn) begin
         waitrequest  <= next_waitrequest;
         readdata     <= next_readdata;
         ctrl         <= next_ctrl;
         flags        <= next_flags;
         halt         <= next_halt;
         running      <= next_running;
         pendBlock    <= next_pendBlock;
         clrCnt       <= next_clrCnt;
         extAutoState <= next_extAutoState;
         startQd      <= startQ;
         extLowQd     <= extLowQ;
         panelD       <= ctrl[`CTRL_PANEL_START];
         loopOpen     <= next_loopOpen;
         mfState      <= next_mfState;
         mfCnt        <= next_mfCnt;
         mfCode       <= next_mfCode;
         mfData       <= next_mfData;
      end
   end

   // Output group: every machine-side output is registered here.
   always_comb begin
      next_machOut = '0;
      next_machOut.haltMotion     = halt || !pin.cycIntN || estop;
      next_machOut.servoZero      = estop;
      next_machOut.spindleStop    = estop;
      next_machOut.spindleEnable  = ctrl[`CTRL_SPINDLE] && pin.spindleOk
                                    && !estop;
      next_machOut.startOut       = ctrl[`CTRL_PANEL_START];
      next_machOut.startOp        = startAccept;
      next_machOut.blockAdvance   = blockGo;
      next_machOut.programSuspend = ANALOG_SPINDLE && running
                                    && ctrl[`CTRL_SPEED_WAIT]
                                    && !pin.speedReached;
      next_machOut.clearCtl       = clrBusy;
      next_machOut.forceAuto      = extAutoState;
      next_machOut.singleMode     = ctrl[`CTRL_SINGLE_SEL] && !extAutoState;
      next_machOut.storeEnable    = ctrl[`CTRL_STORE] && !extAutoState;
      next_machOut.jogEnable      = ctrl[`CTRL_JOG] && !extAutoState;
      next_machOut.diagActive     = pin.diagnosticRequest;
      for (int i = 0; i < 4; i++) begin
         // Expected motion held off during interrupt
         next_machOut.motionExpected[i] = ctrl[`CTRL_EXPECT_LSB + i]
                                          && pin.cycIntN && !estop && !halt
                                          && !loopOpen[i] && !clrBusy;
         next_machOut.axisMoveEnable[i] = next_machOut.motionExpected[i]
                                          && pin.motionOk[i];
      end
      next_machOut.loopOpen = loopOpen;
      next_machOut.mfValid  = (mfState != MF_IDLE);
      next_machOut.mfChange = (mfState == MF_STROBE) && !pin.mfReady;
      next_machOut.mfCode   = mfCode;
      next_machOut.mfData   = mfData;

      // Override honoured with panel or config five
      next_machOut.overrideValid =
         ctrl[`CTRL_PANEL_FIT]
         || (ctrl[`CTRL_CFG_LSB +: 3] == `PANEL_CFG_EXT_SW);
      next_machOut.overrideIsIncr = pin.overrideCodeBit4
                                    && pin.overrideCodeBit3;
      case ({pin.overrideCodeBit2, pin.overrideCodeBit1})
         2'b00:   next_machOut.overrideIncr = 11'h001;
         2'b01:   next_machOut.overrideIncr = 11'h00a;
         2'b10:   next_machOut.overrideIncr = 11'h064;
         default: next_machOut.overrideIncr = 11'h3e8;
      endcase
      case ({pin.overrideCodeBit4, pin.overrideCodeBit3,
             pin.overrideCodeBit2, pin.overrideCodeBit1})
         4'h0:    next_machOut.overridePct = 8'h8c;
         4'h1:    next_machOut.overridePct = 8'h78;
         4'h2:    next_machOut.overridePct = 8'h64;
         4'h3:    next_machOut.overridePct = 8'h50;
         4'h4:    next_machOut.overridePct = 8'h3c;
         4'h5:    next_machOut.overridePct = 8'h28;
         4'h6:    next_machOut.overridePct = 8'h14;
         4'h7:    next_machOut.overridePct = 8'h0a;
         4'h8:    next_machOut.overridePct = 8'h08;
         4'h9:    next_machOut.overridePct = 8'h04;
         4'ha:    next_machOut.overridePct = 8'h02;
         default: next_machOut.overridePct = 8'h00;
      endcase
      // Without a usable switch the feed runs at the nominal rate.
      if (!next_machOut.overrideValid) begin
         next_machOut.overrideIsIncr = 1'b0;
         next_machOut.overridePct    = 8'h64;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         machOut <= '0;
      end else if (clkEn) begin
         machOut <= next_machOut;
      end
   end
endmodule

/* File: tb/mi_checker.sv */
// Concurrent checks on the decoder's machine-side ports.
`timescale 1ns/1ps
module mi_checker
   import mi_pkg::*;
(
   input wire logic         sys_clk,
   input wire logic         rstn,
   input wire machine_in_t  machIn,
   input wire machine_out_t machOut
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   sequence s_ack;
      machOut.mfChange ##1 machIn.mfReady [*4];
   endsequence
   property p_ack; s_ack |=> !machOut.mfChange; endproperty
   a_ack: assert property (p_ack)
      else $error("strobe held after ready");
   property p_quiet;
      !machIn.cycIntN [*4] |-> machOut.motionExpected == 4'h0;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("motion expected during interrupt");
   property p_estop;
      !machIn.estopN [*4] |-> machOut.servoZero && machOut.spindleStop;
   endproperty
   a_estop: assert property (p_estop)
      else $error("stop not forced");
   property p_spin; !machIn.spindleOk [*4] |-> !machOut.spindleEnable;
   endproperty
   a_spin: assert property (p_spin)
      else $error("spindle output enabled");
   property p_axis;
      (machIn.motionOk == 4'h0) [*4] |-> machOut.axisMoveEnable == 4'h0;
   endproperty
   a_axis: assert property (p_axis)
      else $error("axis moves without permission");
   property p_pulse; machOut.startOp |=> !machOut.startOp; endproperty
   a_pulse: assert property (p_pulse)
      else $error("start pulse too long");
   property p_clr; $rose(machOut.clearCtl) |=> machOut.clearCtl [*8];
   endproperty
   a_clr: assert property (p_clr)
      else $error("clear pulse too short");
   property p_auto;
      machOut.forceAuto |-> !(machOut.storeEnable || machOut.jogEnable);
   endproperty
   a_auto: assert property (p_auto)
      else $error("store or jog live in external auto");
endmodule

bind machine_interface_input_decoder mi_checker chk (.sys_clk(sys_clk),
   .rstn(rstn), .machIn(machIn), .machOut(machOut));

/* File: tb/machine_side_model.sv */
// Machine-side relay logic that answers the decoder.
`timescale 1ns/1ps
module machine_side_model
   import mi_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire logic         safe,
   input  wire machine_in_t  drv,
   input  wire machine_out_t machOut,
   output machine_in_t       machIn
);
   logic ack;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) ack <= 1'b0;
      else ack <= machOut.mfChange;
   end
   always_comb begin
      machIn = drv;
      machIn.start = (drv.start | machOut.startOut) & safe;
      machIn.mfReady = ack;
      machIn.speedReached = 1'b1;
   end
endmodule

/* File: tb/machine_interface_input_decoder_tb_top.sv */
// Directed bench for the machine-interface input decoder.
`timescale 1ns/1ps
`include "mi_map.svh"
module machine_interface_input_decoder_tb_top
   import mi_pkg::*;
();
   logic         sys_clk = 1'b0;
   logic         rstn = 1'b0;
   logic [4:0]   address = 5'h00;
   logic         read = 1'b0;
   logic         write = 1'b0;
   logic [31:0]  writedata = 32'h0;
   logic [31:0]  readdata, q;
   logic         waitrequest;
   logic         clkEn = 1'b1;
   machine_in_t  drv, machIn;
   machine_out_t machOut;
   int           fail_count = 0;
   int           comparisons = 0;
   int           n;
   int           ovr[16] = '{140, 120, 100, 80, 60, 40, 20, 10, 8, 4, 2, 0,
                             1, 10, 100, 1000};
   always #12.5 sys_clk = ~sys_clk;
   machine_interface_input_decoder #(.TICK_CYCLES(4)) uut (.sys_clk(sys_clk),
      .rstn(rstn), .clkEn(clkEn), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(4'hf),
      .readdata(readdata), .waitrequest(waitrequest), .machIn(machIn),
      .machOut(machOut));
   machine_side_model model (.sys_clk(sys_clk), .rstn(rstn), .safe(1'b1),
      .drv(drv), .machOut(machOut), .machIn(machIn));
   task final_report(input int extra);
      fail_count += extra;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Each access opens one edge after the caller, so strobes never collide.
   task automatic acc(input logic we, input logic [4:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      address <= a;
      writedata <= d;
      write <= we;
      read <= !we;
      for (i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         if (waitrequest === 1'b0) break;
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (i == 20) final_report(1);
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return machOut.clearCtl;
         1: return machOut.startOp;
         2: return machOut.mfChange;
         default: return machOut.blockAdvance;
      endcase
   endfunction
   task automatic waitv(input int s, input logic v, input int lim);
      for (n = 0; n < lim && sig(s) !== v; n++) @(posedge sys_clk);
      if (n == lim) final_report(1);
   endtask
   initial begin
      drv = '{cycIntN: 1'b1, estopN: 1'b1, nextBlockOk: 1'b1,
              spindleOk: 1'b1, motionOk: 4'hf, openLoopN: 4'hf, default: '0};
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      waitv(0, 1'b1, 4);
      waitv(0, 1'b0, 600);
      chk(n > 390, 1);
      acc(0, `OFS_CTRL, 0);
      chk(q, 0);
      chk(machOut.overrideValid, 0);
      chk(machOut.overridePct, 100);
      acc(1, `OFS_CTRL, 32'h0df5);
      acc(0, 5'h1c, 0);
      chk(q, 0);
      for (int i = 0; i < 16; i++) begin
         {drv.overrideCodeBit4, drv.overrideCodeBit3, drv.overrideCodeBit2,
          drv.overrideCodeBit1} <= i[3:0];
         repeat (4) @(posedge sys_clk);
         q = (i < 12) ? machOut.overridePct : machOut.overrideIncr;
         chk(q, ovr[i]);
         chk(machOut.overrideIsIncr, i >= 12);
      end
      chk(machOut.overrideValid, 1);
      chk(machOut.motionExpected, 4'hf);
      chk(machOut.spindleEnable, 1);
      chk(machOut.storeEnable, 1);
      $display("override table done");
      drv.start <= 1'b1;
      repeat (80) @(posedge sys_clk);
      drv.start <= 1'b0;
      n = 0;
      repeat (140) @(posedge sys_clk) n += machOut.startOp;
      chk(n, 0);
      drv.start <= 1'b1;
      waitv(1, 1'b1, 300);
      drv.start <= 1'b0;
      acc(0, `OFS_STATUS, 0);
      chk(q[2], 1);
      drv.nextBlockOk <= 1'b0;
      acc(1, `OFS_CMD, 32'h2);
      acc(0, `OFS_STATUS, 0);
      chk(q[3], 1);
      drv.nextBlockOk <= 1'b1;
      waitv(3, 1'b1, 20);
      $display("start done");
      drv.cycIntN <= 1'b0;
      repeat (220) @(posedge sys_clk);
      chk(machOut.haltMotion, 1);
      chk(machOut.motionExpected, 4'h0);
      drv.cycIntN <= 1'b1;
      repeat (10) @(posedge sys_clk);
      chk(machOut.haltMotion, 1);
      acc(1, `OFS_CTRL, 32'h1df5);
      waitv(1, 1'b1, 300);
      acc(1, `OFS_CTRL, 32'h0df5);
      chk(machOut.haltMotion, 0);
      $display("cycle interrupt done");
      acc(1, `OFS_MF, 32'h142);
      acc(1, `OFS_MF, 32'h243);
      acc(0, `OFS_FLAGS, 0);
      chk(q[2], 1);
      chk(machOut.mfData, 8'h42);
      chk(machOut.mfCode, 3'h1);
      waitv(2, 1'b1, 300);
      waitv(2, 1'b0, 20);
      $display("machine function done");
      drv.openLoopN <= 4'hd;
      drv.motionOk <= 4'hb;
      repeat (8) @(posedge sys_clk);
      chk(machOut.loopOpen, 4'h0);
      chk(machOut.axisMoveEnable, 4'hb);
      acc(0, `OFS_FLAGS, 0);
      chk(q[5], 1);
      drv.estopN <= 1'b0;
      drv.spindleOk <= 1'b0;
      drv.motionOk <= 4'h0;
      drv.openLoopN <= 4'he;
      drv.diagnosticRequest <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk(machOut.servoZero, 1);
      chk(machOut.spindleStop, 1);
      chk(machOut.loopOpen, 4'h1);
      chk(machOut.diagActive, 1);
      drv.estopN <= 1'b1;
      $display("stop inputs done");
      drv.extAuto <= 1'b1;
      waitv(0, 1'b1, 20);
      chk(machOut.forceAuto, 1);
      chk(machOut.storeEnable, 0);
      chk(machOut.jogEnable, 0);
      waitv(0, 1'b0, 600);
      acc(1, `OFS_CTRL, 32'h1df5);
      waitv(1, 1'b1, 20);
      acc(1, `OFS_CTRL, 32'h0df5);
      drv.extAuto <= 1'b0;
      repeat (220) @(posedge sys_clk);
      acc(0, `OFS_FLAGS, 0);
      chk(q[1], 1);
      chk(machOut.forceAuto, 0);
      drv.extAuto <= 1'b1;
      waitv(0, 1'b1, 20);
      $display("external auto done");
      clkEn <= 1'b0;
      drv.diagnosticRequest <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk(machOut.diagActive, 1);
      clkEn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk(machOut.diagActive, 0);
      $display("clock enable done");
      final_report(0);
   end
endmodule
